//--- common/ssexs_pkg.sv
package ssexs_pkg;
  // register byte offsets on the axi4-lite bus
  localparam logic [7:0] SYSTEM_CONTROL_REG_OFS = 8'h00;
  localparam logic [7:0] CLOCK_DIVIDE_REG_OFS = 8'h04;
  localparam logic [7:0] CONTROL_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  // system control register fields
  localparam int STANDBY_SELECT_BIT = 7;
  localparam int STS_LSB = 4;
  localparam int NMI_EDGE_SELECT_BIT = 3;
  localparam logic [7:0] SYSTEM_CONTROL_REG_RESET = 8'h0b;
  // clock divide register fields
  localparam int DIV_LSB = 0;
  localparam logic [1:0] CLOCK_DIVIDE_REG_RESET = 2'h0;
  // control register fields
  localparam int LINE0_EN_BIT = 0;
  localparam int LINE1_EN_BIT = 1;
  localparam int LINE0_MASK_BIT = 2;
  localparam int LINE1_MASK_BIT = 3;
  localparam int SLEEP_BIT = 8;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // settle counter width: 21 bits, though the largest count, 131072, needs only 18
  localparam int CNT_W = 21;
  localparam logic [CNT_W-1:0] SETTLE_8K = 21'h002000;
  localparam logic [CNT_W-1:0] SETTLE_16K = 21'h004000;
  localparam logic [CNT_W-1:0] SETTLE_32K = 21'h008000;
  localparam logic [CNT_W-1:0] SETTLE_64K = 21'h010000;
  localparam logic [CNT_W-1:0] SETTLE_128K = 21'h020000;
  localparam logic [CNT_W-1:0] SETTLE_1K = 21'h000400;
  // power states, one-hot
  typedef enum logic [4:0] {
    SSEXS_RUN = 5'h01,
    SSEXS_STANDBY = 5'h02,
    SSEXS_SETTLE = 5'h04,
    SSEXS_RESET = 5'h08,
    SSEXS_HWSTBY = 5'h10
  } ssexs_state_t;
  // wake source pins after synchronising
  typedef struct packed {
    logic nmi;
    logic req0_n;
    logic req1_n;
    logic reset_n;
    logic hwstby_n;
  } ssexs_pins_t;
endpackage

//--- hw/ssexs_top.sv
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
module ssexs_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic nmi_pin,
  input wire logic ext_req_line0,
  input wire logic ext_req_line1,
  input wire logic reset_pin_n,
  input wire logic hw_standby_pin_n,
  output logic osc_run,
  output logic clk_gate_open,
  output logic standby_active,
  output logic hw_standby,
  output logic irq_exc_start,
  output logic reset_exc_start,
  output logic cpu_reset
);
  // two-flop synchronisers for all pins
  ssexs_pkg::ssexs_pins_t pin_s1_q;
  ssexs_pkg::ssexs_pins_t pin_s2_q;
  logic nmi_prev_q; // previous synced nmi for edge detect
  // registers
  // standby select, settle select and nmi edge select live here
  logic [7:0] system_control_reg_q;
  // divider setting, scales the settle wait
  logic [1:0] clock_divide_reg_q;
  // request line enables and cpu masks
  logic [3:0] ctrl_q;
  // one-hot power state
  ssexs_pkg::ssexs_state_t state_q;
  // states left in the settle wait
  logic [ssexs_pkg::CNT_W-1:0] cnt_q;
  logic [2:0] pre_q; // divided clock prescaler
  // bus handshake state
  // address taken, waiting for data
  logic aw_hold_q;
  // data taken, waiting for address
  logic w_hold_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  // one-cycle sleep strobe
  logic sleep_req;

  // decode settle select to a count of states
  // the divider is applied by the prescaler, not here
  function automatic logic [ssexs_pkg::CNT_W-1:0] settle_count(input logic [2:0] sel);
    unique case (sel)
      3'h0: settle_count = ssexs_pkg::SETTLE_8K;
      3'h1: settle_count = ssexs_pkg::SETTLE_16K;
      3'h2: settle_count = ssexs_pkg::SETTLE_32K;
      3'h3: settle_count = ssexs_pkg::SETTLE_64K;
      3'h4: settle_count = ssexs_pkg::SETTLE_128K;
      3'h5: settle_count = ssexs_pkg::SETTLE_1K;
      // illegal codes fall back to the longest wait, the safe side
      default: settle_count = ssexs_pkg::SETTLE_128K;
    endcase
  endfunction

  // pin synchronisers
  // idle level is high on every pin, so no false nmi edge after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= '{nmi: 1'b1, req0_n: 1'b1, req1_n: 1'b1, reset_n: 1'b1, hwstby_n: 1'b1};
      pin_s2_q <= '{nmi: 1'b1, req0_n: 1'b1, req1_n: 1'b1, reset_n: 1'b1, hwstby_n: 1'b1};
      nmi_prev_q <= 1'b1;
    end else begin
      pin_s1_q <= '{nmi: nmi_pin, req0_n: ext_req_line0, req1_n: ext_req_line1,
                    reset_n: reset_pin_n, hwstby_n: hw_standby_pin_n};
      pin_s2_q <= pin_s1_q;
      nmi_prev_q <= pin_s2_q.nmi;
    end
  end

  // wake qualification
  logic nmi_edge;
  logic req_wake;
  logic write_fire;
  logic settle_done;
  always_comb begin
    // falling when edge select is 0, rising when 1
    nmi_edge = system_control_reg_q[ssexs_pkg::NMI_EDGE_SELECT_BIT]
               ? (pin_s2_q.nmi && !nmi_prev_q)
               : (!pin_s2_q.nmi && nmi_prev_q);
    // enabled and unmasked request lines only
    req_wake = (!pin_s2_q.req0_n && ctrl_q[ssexs_pkg::LINE0_EN_BIT]
                && !ctrl_q[ssexs_pkg::LINE0_MASK_BIT])
            || (!pin_s2_q.req1_n && ctrl_q[ssexs_pkg::LINE1_EN_BIT]
                && !ctrl_q[ssexs_pkg::LINE1_MASK_BIT]);
    // last settle cycle, with no reset or standby pin pulling elsewhere
    settle_done = state_q == ssexs_pkg::SSEXS_SETTLE && cnt_q == '0
                  && pin_s2_q.reset_n && pin_s2_q.hwstby_n;
  end

  // write channel: take address and data in any order
  // response waits until both halves are held
  assign write_fire = aw_hold_q && w_hold_q && !bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else begin
      // each ready pulses one cycle after its valid is seen
      awready <= !aw_hold_q && awvalid && !awready;
      wready <= !w_hold_q && wvalid && !wready;
      if (awvalid && awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (write_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid <= 1'b1;
        // status is read-only; it and unmapped offsets get slverr
        bresp <= (aw_addr_q == ssexs_pkg::SYSTEM_CONTROL_REG_OFS[3:0]
                  || aw_addr_q == ssexs_pkg::CLOCK_DIVIDE_REG_OFS[3:0]
                  || aw_addr_q == ssexs_pkg::CONTROL_OFS[3:0]) ? 2'h0 : 2'h2;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // sleep instruction strobe from the control register
  assign sleep_req = write_fire && aw_addr_q == ssexs_pkg::CONTROL_OFS[3:0]
                     && w_strb_q[1] && w_data_q[ssexs_pkg::SLEEP_BIT];

  // configuration registers, byte lane 0 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_control_reg_q <= ssexs_pkg::SYSTEM_CONTROL_REG_RESET;
      clock_divide_reg_q <= ssexs_pkg::CLOCK_DIVIDE_REG_RESET;
      ctrl_q <= ssexs_pkg::CTRL_RESET;
    end else if (write_fire && w_strb_q[0]) begin
      // the sleep strobe rides on byte lane 1 and is not stored here
      // standby select stays set after an interrupt wake; only a write or aresetn clears it
      if (aw_addr_q == ssexs_pkg::SYSTEM_CONTROL_REG_OFS[3:0]) begin
        system_control_reg_q <= w_data_q[7:0];
      end
      if (aw_addr_q == ssexs_pkg::CLOCK_DIVIDE_REG_OFS[3:0]) begin
        clock_divide_reg_q <= w_data_q[ssexs_pkg::DIV_LSB +: 2];
      end
      if (aw_addr_q == ssexs_pkg::CONTROL_OFS[3:0]) begin
        ctrl_q <= w_data_q[3:0];
      end
    end
  end

  // read channel, one cycle after address taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end else begin
      arready <= arvalid && !arready && !rvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp <= 2'h0;
        // araddr is still held by the master at this edge
        unique case (araddr)
          ssexs_pkg::SYSTEM_CONTROL_REG_OFS[3:0]: rdata <= {24'h0, system_control_reg_q};
          ssexs_pkg::CLOCK_DIVIDE_REG_OFS[3:0]: rdata <= {30'h0, clock_divide_reg_q};
          ssexs_pkg::CONTROL_OFS[3:0]: rdata <= {28'h0, ctrl_q};
          ssexs_pkg::STATUS_OFS[3:0]: rdata <= {27'h0, state_q};
          default: begin
            rdata <= 32'h0;
            rresp <= 2'h2; // unmapped
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // power state machine; hw-standby pin has top priority
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ssexs_pkg::SSEXS_RUN;
    end else if (!pin_s2_q.hwstby_n) begin
      state_q <= ssexs_pkg::SSEXS_HWSTBY;
    end else begin
      unique case (state_q)
        ssexs_pkg::SSEXS_RUN: begin
          // sleep with standby select set halts everything
          if (sleep_req && system_control_reg_q[ssexs_pkg::STANDBY_SELECT_BIT]) begin
            state_q <= ssexs_pkg::SSEXS_STANDBY;
          end
        end
        ssexs_pkg::SSEXS_STANDBY: begin
          // only these sources wake; reset beats interrupt
          if (!pin_s2_q.reset_n) begin
            state_q <= ssexs_pkg::SSEXS_RESET;
          end else if (nmi_edge || req_wake) begin
            state_q <= ssexs_pkg::SSEXS_SETTLE;
          end
        end
        ssexs_pkg::SSEXS_SETTLE: begin
          // reset pin cuts the settle wait short
          if (!pin_s2_q.reset_n) begin
            state_q <= ssexs_pkg::SSEXS_RESET;
          end else if (cnt_q == '0) begin
            state_q <= ssexs_pkg::SSEXS_RUN;
          end
        end
        ssexs_pkg::SSEXS_RESET: begin
          // external driver holds the pin for settling
          if (pin_s2_q.reset_n) begin
            state_q <= ssexs_pkg::SSEXS_RUN;
          end
        end
        ssexs_pkg::SSEXS_HWSTBY: begin
          // leaves only through a reset pin cycle
          if (!pin_s2_q.reset_n) begin
            state_q <= ssexs_pkg::SSEXS_RESET;
          end
        end
        // a broken one-hot code recovers to run
        default: state_q <= ssexs_pkg::SSEXS_RUN;
      endcase
    end
  end

  // settle counter: loaded at wake, one step per divided clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      pre_q <= 3'h0;
    end else if (state_q == ssexs_pkg::SSEXS_STANDBY) begin
      // kept loaded all through standby, so the wake starts from the full count
      cnt_q <= settle_count(system_control_reg_q[ssexs_pkg::STS_LSB +: 3]);
      pre_q <= 3'h0;
    end else if (state_q == ssexs_pkg::SSEXS_SETTLE && cnt_q != '0) begin
      // divider n gives one step every 2**n system clocks
      // a 3-bit prescaler is enough for the largest divider of 8
      if (pre_q == ((3'h1 << clock_divide_reg_q) - 3'h1)) begin
        pre_q <= 3'h0;
        cnt_q <= cnt_q - 1'b1;
      end else begin
        pre_q <= pre_q + 3'h1;
      end
    end
  end

  // outputs, all registered from the state, the settle count and the synced pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_run <= 1'b1;
      clk_gate_open <= 1'b1;
      standby_active <= 1'b0;
      hw_standby <= 1'b0;
      irq_exc_start <= 1'b0;
      reset_exc_start <= 1'b0;
      cpu_reset <= 1'b0;
    end else begin
      // oscillator stops only while fully halted
      osc_run <= state_q != ssexs_pkg::SSEXS_STANDBY && state_q != ssexs_pkg::SSEXS_HWSTBY;
      // gated during settling; opens with the handling pulse, at once on reset wake
      clk_gate_open <= state_q == ssexs_pkg::SSEXS_RUN || settle_done
                    || state_q == ssexs_pkg::SSEXS_RESET;
      // the last settle cycle already counts as awake
      standby_active <= state_q == ssexs_pkg::SSEXS_STANDBY
                     || (state_q == ssexs_pkg::SSEXS_SETTLE && !settle_done);
      hw_standby <= state_q == ssexs_pkg::SSEXS_HWSTBY;
      // cpu stays in reset in both reset and hardware standby
      cpu_reset <= state_q == ssexs_pkg::SSEXS_RESET || state_q == ssexs_pkg::SSEXS_HWSTBY;
      // handling pulses last one cycle
      irq_exc_start <= settle_done;
      reset_exc_start <= state_q == ssexs_pkg::SSEXS_RESET && pin_s2_q.reset_n
                      && pin_s2_q.hwstby_n;
    end
  end
endmodule

//--- verification/ssexs_props.sv
module ssexs_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic reset_pin_n,
  input wire logic hw_standby_pin_n,
  input wire logic clk_gate_open,
  input wire logic standby_active,
  input wire logic hw_standby,
  input wire logic irq_exc_start,
  input wire logic reset_exc_start,
  input wire logic cpu_reset
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // bus answers stand until the master takes them
  a_bresp_holds: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped early");
  a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before taken");
  // cpu clocks stay shut for the whole settle wait
  a_gate_in_standby: assert property (standby_active |-> !clk_gate_open)
    else $error("cpu clock open while settling");
  a_irq_clk_open: assert property (irq_exc_start |-> clk_gate_open ##1 !irq_exc_start)
    else $error("handling began without clock");
  // reset pin wake skips the settle count
  a_reset_wake_now: assert property (!reset_pin_n && standby_active |-> ##[1:5] (clk_gate_open && cpu_reset))
    else $error("reset wake not immediate");
  a_hw_entry: assert property (!hw_standby_pin_n |-> ##[1:5] hw_standby)
    else $error("hw standby not entered");
  a_hw_held_reset: assert property (hw_standby |-> cpu_reset && !clk_gate_open)
    else $error("cpu active in hw standby");
  a_rst_exc_cause: assert property (reset_exc_start |-> $past(cpu_reset) && reset_pin_n)
    else $error("reset handling without release");
  c_irq_wake: cover property (irq_exc_start);
  c_rst_wake: cover property (reset_exc_start);
  c_hw_entry: cover property (hw_standby);
endmodule

bind ssexs_top ssexs_props u_props (.aclk, .aresetn, .bvalid, .bready, .rvalid, .rready,
  .rdata, .reset_pin_n, .hw_standby_pin_n, .clk_gate_open, .standby_active, .hw_standby,
  .irq_exc_start, .reset_exc_start, .cpu_reset);

//--- verification/ssexs_pins_model.sv
module ssexs_pins_model #(
  parameter int RST_HOLD = 32
) (
  input wire logic aclk,
  output logic nmi_pin,
  output logic ext_req_line0,
  output logic ext_req_line1,
  output logic reset_pin_n,
  output logic hw_standby_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  ssexs_pkg::ssexs_pins_t pins_q; // board pin levels, all idle high
  assign {nmi_pin, ext_req_line0, ext_req_line1, reset_pin_n, hw_standby_pin_n} = pins_q;
  initial pins_q = 5'h1f;
  // one pin changes just after an edge
  task automatic set_pin(input int idx, input logic v);
    @(posedge aclk);
    pins_q[idx] <= v;
  endtask
  // reset stays low for RST_HOLD clocks, short of any settle count, standby pin lifted meanwhile
  task automatic hold_reset();
    @(posedge aclk);
    pins_q.reset_n <= 1'b0;
    pins_q.hwstby_n <= 1'b1;
    repeat (RST_HOLD) @(posedge aclk);
    pins_q.reset_n <= 1'b1;
  endtask
endmodule

//--- verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp, rs;
  logic nmi_pin, ext_req_line0, ext_req_line1, reset_pin_n, hw_standby_pin_n;
  logic osc_run, clk_gate_open, standby_active, hw_standby, irq_exc_start;
  logic reset_exc_start, cpu_reset;
  int fails, num_checks, n;
  int settle_tbl[6] = '{8192, 16384, 32768, 65536, 131072, 1024};
  int code_tbl[7] = '{5, 5, 5, 5, 0, 1, 2};
  int div_tbl[7] = '{0, 1, 2, 3, 0, 0, 0};
  // bench stands for an external clock: crystal minimum wait not kept
  ssexs_top u_ssexs_top (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .nmi_pin, .ext_req_line0, .ext_req_line1, .reset_pin_n,
    .hw_standby_pin_n, .osc_run, .clk_gate_open, .standby_active, .hw_standby,
    .irq_exc_start, .reset_exc_start, .cpu_reset);
  ssexs_pins_model u_pins (.aclk, .nmi_pin, .ext_req_line0, .ext_req_line1, .reset_pin_n,
    .hw_standby_pin_n);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic tmo();
    fails++;
    print_verdict();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  // write: address and data offered together, held until each is taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ka, kw, kb;
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    do begin
      @(negedge aclk);
      {ka, kw, kb, rs} = {awready & awvalid, wready & wvalid, bvalid, bresp};
      k++;
      @(posedge aclk);
      if (ka) awvalid <= 1'b0;
      if (kw) wvalid <= 1'b0;
    end while (kb !== 1'b1 && k < 50);
    bready <= 1'b0;
    if (k >= 50) tmo();
  endtask
  task automatic rd(input logic [3:0] a);
    logic ka, kr;
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    do begin
      @(negedge aclk);
      {ka, kr, v} = {arready & arvalid, rvalid, rdata};
      k++;
      @(posedge aclk);
      if (ka) arvalid <= 1'b0;
    end while (kr !== 1'b1 && k < 50);
    rready <= 1'b0;
    if (k >= 50) tmo();
  endtask
  task automatic st(input logic [31:0] e);
    rd(4'hc);
    chk(v, e);
  endtask
  // counts cycles from a pin change to the chosen handling pulse
  task automatic wait_pulse(input logic rst);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while ((rst ? reset_exc_start : irq_exc_start) !== 1'b1 && n < 40000);
    if (n >= 40000) tmo();
  endtask
  task automatic s_regs();
    rd(4'h0);
    chk(v, 32'h0000000b);
    rd(4'h4);
    chk(v, 32'h0);
    wr(4'hc, 32'h1, 4'hf);
    chk(32'(rs), 32'h2); // status is read-only
  endtask
  // sources rotate: line0, line1, nmi falling, nmi rising
  task automatic s_wake(input int i);
    int lo, pin;
    lo = settle_tbl[code_tbl[i]] << div_tbl[i];
    pin = (i % 4 == 0) ? 3 : (i % 4 == 1) ? 2 : 4;
    wr(4'h8, 32'h3, 4'hf);
    wr(4'h4, 32'(div_tbl[i]), 4'hf);
    wr(4'h0, 32'h80 | (code_tbl[i] << 4) | ((i % 4 == 3) << 3), 4'hf);
    u_pins.set_pin(4, i % 4 != 3);
    repeat (6) @(posedge aclk);
    wr(4'h8, 32'h103, 4'h3);
    st(32'h2);
    chk(32'({osc_run, standby_active, clk_gate_open}), 32'h2);
    u_pins.set_pin(pin, i % 4 == 3);
    wait_pulse(1'b0);
    chk(32'(clk_gate_open), 32'h1);
    chk(32'(n >= lo && n <= lo + 8), 32'h1);
    u_pins.set_pin(pin, 1'b1);
    st(32'h1);
  endtask
  task automatic s_blocked();
    wr(4'h8, 32'h100, 4'h3);
    u_pins.set_pin(3, 1'b0);
    repeat (1200) @(posedge aclk);
    st(32'h2);
    u_pins.set_pin(3, 1'b1);
    wr(4'h8, 32'ha, 4'hf);
    u_pins.set_pin(2, 1'b0);
    repeat (1200) @(posedge aclk);
    st(32'h2);
    u_pins.set_pin(2, 1'b1);
    u_pins.set_pin(1, 1'b0);
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    chk(32'({osc_run, clk_gate_open, cpu_reset}), 32'h7);
    u_pins.hold_reset();
    wait_pulse(1'b1);
    st(32'h1);
  endtask
  task automatic s_hwstby();
    wr(4'h0, 32'hd0, 4'hf);
    wr(4'h8, 32'h100, 4'h3);
    u_pins.set_pin(0, 1'b0);
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    chk(32'({hw_standby, cpu_reset}), 32'h3);
    st(32'h10);
    u_pins.set_pin(1, 1'b0);
    u_pins.hold_reset();
    wait_pulse(1'b1);
    st(32'h1);
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wstrb, wdata} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    s_regs();
    for (int i = 0; i < 7; i++) s_wake(i);
    s_blocked();
    s_hwstby();
    print_verdict();
  end
endmodule
